// ### common/ssspi_defines.svh
// Register map, field positions, mode codes and divider counts
// Assumes inclusion by bare name from every design file
`ifndef SSSPI_DEFINES_SVH
`define SSSPI_DEFINES_SVH
`define SSSPI_AW        12
`define SSSPI_ADDR_STAT 12'h000
`define SSSPI_ADDR_CTL  12'h004
`define SSSPI_ADDR_BUF  12'h008
`define SSSPI_ADDR_OD   12'h00c
`define SSSPI_IDX_STAT  2'h0
`define SSSPI_IDX_CTL   2'h1
`define SSSPI_IDX_BUF   2'h2
`define SSSPI_IDX_OD    2'h3
`define SSSPI_C_WRITE_COLLISION_FLAG    7
`define SSSPI_C_OVF     6
`define SSSPI_C_EN      5
`define SSSPI_C_CKP     4
`define SSSPI_C_MODE    3:0
`define SSSPI_S_SMP     7
`define SSSPI_S_CKE     6
`define SSSPI_S_STOP    4
`define SSSPI_S_BF      0
`define SSSPI_OD_SEL    0
`define SSSPI_CTL_RST   8'h00
`define SSSPI_M_DIV4    4'h0
`define SSSPI_M_DIV16   4'h1
`define SSSPI_M_DIV64   4'h2
`define SSSPI_M_TMR     4'h3
`define SSSPI_M_SLV_SS  4'h4
`define SSSPI_M_SLV     4'h5
`define SSSPI_M_DIV8    4'ha
`define SSSPI_HALF_DIV4  6'h02
`define SSSPI_HALF_DIV8  6'h04
`define SSSPI_HALF_DIV16 6'h08
`define SSSPI_HALF_DIV64 6'h20
`define SSSPI_LAST_HALF 4'hf
`define SSSPI_LAST_BIT  4'h7
`endif

// ### common/ssspi_if.sv
// Internal links between the core, its bit-rate divider and bus slave
// Assumes one clock domain shared by all parties
`timescale 1ns/1ns
interface ssspi_if;
    logic       run;
    logic [3:0] mode;
    logic       timerTick;
    logic       halfTick;
    logic       wr;
    logic       rd;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport baud (input run, mode, timerTick, output halfTick);
    modport apb  (input rdata, output wr, rd, idx, wdata);
    modport core (input halfTick, wr, rd, idx, wdata,
                  output run, mode, timerTick, rdata);
endinterface : ssspi_if

// ### common/ssspi_pkg.sv
// Types shared by the serial port modules
// Assumes nothing beyond a SystemVerilog compiler
package ssspi_pkg;
    typedef enum logic [1:0] {SSSPI_OFF, SSSPI_MASTER, SSSPI_SLAVE}
        ssspi_kind_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic       sample_phase;
        logic       cke;
        logic       stop;
        logic       bf;
        logic [7:0] rxBuf;
        logic [7:0] sr;
        logic       out;
        logic       samp;
        logic [3:0] cnt;
        logic       busy;
        logic       sckPrev;
        logic       sck;
        logic       od;
        logic       intPulse;
    } ssspi_core_t;
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } ssspi_baud_t;
    typedef struct packed {
        logic [31:0] rdata;
    } ssspi_apb_t;
endpackage : ssspi_pkg

// ### hdl/ssspi_apb.sv
// APB slave: address decode, strobes and registered read data
// Assumes zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/1ns
`include "ssspi_defines.svh"
module ssspi_apb (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [`SSSPI_AW-1:0]   paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    ssspi_if.apb                        bus
);
    ssspi_pkg::ssspi_apb_t st_reg;
    ssspi_pkg::ssspi_apb_t st_next;
    logic                  hit;
    logic [1:0]            idx;

    always_comb begin
        hit = 1'b1;
        case (paddr)
            `SSSPI_ADDR_STAT: idx = `SSSPI_IDX_STAT;
            `SSSPI_ADDR_CTL:  idx = `SSSPI_IDX_CTL;
            `SSSPI_ADDR_BUF:  idx = `SSSPI_IDX_BUF;
            `SSSPI_ADDR_OD:   idx = `SSSPI_IDX_OD;
            default: begin
                idx = `SSSPI_IDX_STAT;
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // Read data is captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            st_next.rdata = hit ? {24'h000000, bus.rdata} : 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata    = st_reg.rdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !hit;
    assign bus.wr    = psel && penable && pwrite && hit;
    assign bus.rd    = psel && penable && !pwrite && hit;
    assign bus.idx   = idx;
    assign bus.wdata = pwdata[7:0];
endmodule : ssspi_apb

// ### hdl/ssspi_baud.sv
// Half-period tick generator for master serial clock
// Assumes run stays high for the whole transfer
`timescale 1ns/1ns
`include "ssspi_defines.svh"
module ssspi_baud (
    input  wire logic clk,
    input  wire logic sys_rst,
    ssspi_if.baud     bus
);
    ssspi_pkg::ssspi_baud_t st_reg;
    ssspi_pkg::ssspi_baud_t st_next;
    logic [5:0]             halfLen;

    always_comb begin
        case (bus.mode)
            `SSSPI_M_DIV16: halfLen = `SSSPI_HALF_DIV16;
            `SSSPI_M_DIV64: halfLen = `SSSPI_HALF_DIV64;
            `SSSPI_M_DIV8:  halfLen = `SSSPI_HALF_DIV8;
            default:        halfLen = `SSSPI_HALF_DIV4;
        endcase
    end

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!bus.run) begin
            st_next.cnt = 6'h00;
        end else if (bus.mode == `SSSPI_M_TMR) begin
            // One timer pulse per half period gives timer rate over two
            st_next.tick = bus.timerTick;
        end else if (st_reg.cnt == halfLen - 6'h01) begin
            st_next.tick = 1'b1;
            st_next.cnt  = 6'h00;
        end else begin
            st_next.cnt = st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.halfTick = st_reg.tick;
endmodule : ssspi_baud

// ### hdl/ssspi_core.sv
// Synchronous serial port, SPI operation, with APB register access
// Assumes pins sampled on clk; pad logic resolves out/oe pairs
//
// Behaviour
// - Full received byte moves to buffer, then buffer-full and interrupt set.
// - Software buffer write loads the same byte into buffer and shifter.
// - Shifter moves data out and in most significant bit first.
// - Buffer write during a transfer is dropped and collision flag set.
// - Slave byte arriving onto unread buffer sets overflow and is dropped.
// - Master transfers start on buffer write; overflow never set in master.
// - Buffer-full shows a waiting byte; reading the buffer clears it.
// - Enable bit in a valid mode claims data pin, clock pin (master only), select pin (mode 4 only); clear frees them.
// - Stop indicator is cleared whenever the enable bit is clear.
// - Clock polarity bit sets serial clock idle level, one meaning high.
// - Clock edge bit picks active-to-idle or idle-to-active data change.
// - Master samples input at end or middle of output time per sample bit.
// - Mode codes 0, 1, 2 give master at clock over 4, 16, 64.
// - Mode 3 gives master at half timer rate; mode a over 8.
// - Mode 4 slave with select control; mode 5 slave without it.
// - Other mode codes give no serial port behaviour.
// - Control register fully read/write; status low six bits read-only.
// - Shifter is never directly readable or writable by software.
// - Open-drain select lets data and clock outputs drive only low.
// - Slave with select control: low select shifts, high releases data out.
// - Port reset by high select or enable clear zeroes the bit counter.
// - Slave shifts on external clock edges; flag set at last bit.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "ssspi_defines.svh"
module ssspi_core (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic [`SSSPI_AW-1:0] paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 timerTick,
    input  wire logic                 sckIn,
    output logic                      sckOut,
    output logic                      sckOe,
    input  wire logic                 sdiIn,
    output logic                      sdoOut,
    output logic                      sdoOe,
    input  wire logic                 slaveSelectN,
    output logic                      portIntFlag,
    output logic                      portActive,
    output logic                      ssPinOwned
);
    ssspi_pkg::ssspi_core_t st_reg;
    ssspi_pkg::ssspi_core_t st_next;
    ssspi_pkg::ssspi_kind_t kind;
    logic                   isMaster;
    logic                   isSlave;
    logic                   ssCtl;
    logic                   ssHigh;
    logic                   sckAct;
    logic                   lead;
    logic                   trail;
    logic                   sampleEdge;
    logic                   changeEdge;
    logic                   wrCtl;
    logic                   wrStat;
    logic                   wrBuf;
    logic                   wrOd;
    logic                   rdBuf;
    logic                   inBit;
    logic                   done;
    logic                   drop;
    logic [7:0]             newByte;
    logic                   sckDrive;
    logic                   sdoDrive;

    ssspi_if bus ();

    ssspi_baud u_baud (
        .clk     (clk),
        .sys_rst (sys_rst),
        .bus     (bus)
    );

    ssspi_apb u_apb (
        .clk     (clk),
        .sys_rst (sys_rst),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus)
    );

    // Mode decode; unlisted codes leave the port idle
    always_comb begin
        kind = ssspi_pkg::SSSPI_OFF;
        if (st_reg.ctrl[`SSSPI_C_EN]) begin
            case (st_reg.ctrl[`SSSPI_C_MODE])
                `SSSPI_M_DIV4, `SSSPI_M_DIV16, `SSSPI_M_DIV64: begin
                    kind = ssspi_pkg::SSSPI_MASTER;
                end
                `SSSPI_M_TMR, `SSSPI_M_DIV8: begin
                    kind = ssspi_pkg::SSSPI_MASTER;
                end
                `SSSPI_M_SLV_SS, `SSSPI_M_SLV: begin
                    kind = ssspi_pkg::SSSPI_SLAVE;
                end
                default: begin
                    kind = ssspi_pkg::SSSPI_OFF;
                end
            endcase
        end
    end

    assign isMaster = kind == ssspi_pkg::SSSPI_MASTER;
    assign isSlave  = kind == ssspi_pkg::SSSPI_SLAVE;
    assign ssCtl    = st_reg.ctrl[`SSSPI_C_MODE] == `SSSPI_M_SLV_SS;
    assign ssHigh   = isSlave && ssCtl && slaveSelectN;

    // Slave clock edges, relative to the programmed idle level
    assign sckAct     = sckIn ^ st_reg.ctrl[`SSSPI_C_CKP];
    assign lead       = sckAct && !st_reg.sckPrev;
    assign trail      = !sckAct && st_reg.sckPrev;
    assign sampleEdge = st_reg.cke ? lead : trail;
    assign changeEdge = st_reg.cke ? trail : lead;

    assign wrCtl  = bus.wr && bus.idx == `SSSPI_IDX_CTL;
    assign wrStat = bus.wr && bus.idx == `SSSPI_IDX_STAT;
    assign wrBuf  = bus.wr && bus.idx == `SSSPI_IDX_BUF;
    assign wrOd   = bus.wr && bus.idx == `SSSPI_IDX_OD;
    assign rdBuf  = bus.rd && bus.idx == `SSSPI_IDX_BUF;

    assign newByte = {st_reg.sr[6:0], inBit};
    assign drop    = isSlave && st_reg.bf && !rdBuf;

    always_comb begin
        st_next          = st_reg;
        st_next.intPulse = 1'b0;
        st_next.sckPrev  = sckAct;
        done             = 1'b0;
        inBit            = sdiIn;
        if (wrCtl) begin
            st_next.ctrl = bus.wdata;
        end
        if (wrStat) begin
            st_next.sample_phase = bus.wdata[`SSSPI_S_SMP];
            st_next.cke = bus.wdata[`SSSPI_S_CKE];
        end
        if (wrOd) begin
            st_next.od = bus.wdata[`SSSPI_OD_SEL];
        end
        if (rdBuf) begin
            st_next.bf = 1'b0;
        end
        // Master: even half ends at mid-bit, odd half ends at bit end
        if (isMaster && st_reg.busy && bus.halfTick) begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (!st_reg.cnt[0]) begin
                if (!st_reg.sample_phase) begin
                    st_next.samp = sdiIn;
                end
            end else begin
                inBit       = st_reg.sample_phase ? sdiIn : st_reg.samp;
                st_next.sr  = {st_reg.sr[6:0], inBit};
                st_next.out = st_reg.sr[6];
                done        = st_reg.cnt == `SSSPI_LAST_HALF;
            end
        end
        // Slave: shift on the external clock while selected
        if (isSlave && !ssHigh) begin
            if (sampleEdge) begin
                st_next.sr   = {st_reg.sr[6:0], sdiIn};
                st_next.cnt  = st_reg.cnt + 4'h1;
                st_next.busy = 1'b1;
                done         = st_reg.cnt == `SSSPI_LAST_BIT;
            end
            if (changeEdge) begin
                st_next.out = st_reg.sr[7];
                // Closing edge after the eighth sample must not reopen
                if (!st_reg.cke) begin
                    st_next.busy = 1'b1;
                end
            end
        end
        if (done) begin
            st_next.busy     = 1'b0;
            st_next.cnt      = 4'h0;
            st_next.intPulse = 1'b1;
            if (drop) begin
                st_next.ctrl[`SSSPI_C_OVF] = 1'b1;
            end else begin
                st_next.rxBuf = {st_reg.sr[6:0], inBit};
                st_next.bf    = 1'b1;
            end
        end
        if (wrBuf) begin
            if (st_reg.busy) begin
                // Hardware sets it only here; software owns the clear
                st_next.ctrl[`SSSPI_C_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
                st_next.rxBuf = bus.wdata;
                st_next.sr    = bus.wdata;
                st_next.out   = bus.wdata[7];
                st_next.cnt   = 4'h0;
                st_next.busy  = st_next.busy || isMaster;
            end
        end
        if (!(isMaster || isSlave) || ssHigh) begin
            st_next.cnt  = 4'h0;
            st_next.busy = 1'b0;
        end
        if (!st_reg.ctrl[`SSSPI_C_EN]) begin
            st_next.stop = 1'b0;
        end
        if (isMaster && st_next.busy) begin
            st_next.sck = st_next.ctrl[`SSSPI_C_CKP]
                ^ (st_next.cke ? st_next.cnt[0] : !st_next.cnt[0]);
        end else begin
            st_next.sck = st_next.ctrl[`SSSPI_C_CKP];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Register read view; the shifter itself has no address
    always_comb begin
        case (bus.idx)
            `SSSPI_IDX_STAT: bus.rdata = {st_reg.sample_phase, st_reg.cke, 1'b0,
                                          st_reg.stop, 3'h0, st_reg.bf};
            `SSSPI_IDX_CTL:  bus.rdata = st_reg.ctrl;
            `SSSPI_IDX_BUF:  bus.rdata = st_reg.rxBuf;
            default:         bus.rdata = {7'h00, st_reg.od};
        endcase
    end

    assign bus.run       = isMaster && st_reg.busy;
    assign bus.mode      = st_reg.ctrl[`SSSPI_C_MODE];
    assign bus.timerTick = timerTick;

    // Pins belong to the port only while enabled in a valid mode
    assign sckDrive = isMaster;
    assign sdoDrive = isMaster || (isSlave && !ssHigh);
    // Open drain: drive low only, release for high
    assign sckOut = st_reg.od ? 1'b0 : st_reg.sck;
    assign sckOe  = sckDrive && !(st_reg.od && st_reg.sck);
    assign sdoOut = st_reg.od ? 1'b0 : st_reg.out;
    assign sdoOe  = sdoDrive && !(st_reg.od && st_reg.out);

    assign portIntFlag = st_reg.intPulse;
    assign portActive  = st_reg.ctrl[`SSSPI_C_EN];
    assign ssPinOwned  = isSlave && ssCtl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RX_LOAD:
    assert property (done && !drop
        |=> st_reg.bf && st_reg.rxBuf == $past(newByte) && st_reg.intPulse)
        else $error("Received byte not moved to buffer");
    AST_TX_LOAD:
    assert property (wrBuf && !st_reg.busy
        |=> st_reg.sr == $past(bus.wdata) && st_reg.rxBuf == $past(bus.wdata))
        else $error("Buffer write did not load shifter and buffer");
    AST_MSB_OUT:
    assert property (wrBuf && !st_reg.busy |=> st_reg.out == $past(bus.wdata[7]))
        else $error("First bit out is not the top bit");
    AST_COLLIDE:
    assert property (wrBuf && st_reg.busy
        |=> st_reg.ctrl[`SSSPI_C_WRITE_COLLISION_FLAG] && !$rose(st_reg.busy))
        else $error("Collision not flagged");
    AST_OVF_SLAVE:
    assert property ($rose(st_reg.ctrl[`SSSPI_C_OVF]) && !$past(wrCtl)
        |-> $past(isSlave) && $past(done))
        else $error("Overflow set outside slave completion");
    AST_BF_CLEAR:
    assert property (rdBuf && !done |=> !st_reg.bf)
        else $error("Buffer read did not clear full flag");
    AST_PINS_FREE:
    assert property (!st_reg.ctrl[`SSSPI_C_EN] |-> !sckOe && !sdoOe)
        else $error("Pins driven while disabled");
    AST_STOP_CLR:
    assert property (!st_reg.ctrl[`SSSPI_C_EN] |=> !st_reg.stop)
        else $error("Stop bit not cleared while disabled");
    AST_IDLE_LVL:
    assert property (isMaster && !st_reg.busy && !$past(st_reg.busy)
        && $stable(st_reg.ctrl) |-> st_reg.sck == st_reg.ctrl[`SSSPI_C_CKP])
        else $error("Idle clock level wrong");
    AST_SS_RELEASE:
    assert property (isSlave && ssCtl && slaveSelectN |-> !sdoOe)
        else $error("Data out driven while deselected");
    AST_SS_RESET:
    assert property (ssHigh ##1 ssHigh |-> st_reg.cnt == 4'h0 && !st_reg.busy)
        else $error("Bit counter not cleared by select");

    CVR_MASTER_BYTE: cover property (isMaster && done);
    CVR_SLAVE_DROP:  cover property (done && drop);
    CVR_COLLIDE:     cover property (wrBuf && st_reg.busy);
    CVR_SS_ABORT:    cover property (st_reg.busy && isSlave ##1 ssHigh);
endmodule : ssspi_core

// ### tb/ssspi_peer.sv
// SPI peer device: slave to a master port, or master of a slave port
// Assumes clock idle low, data changed on the falling clock edge
`timescale 1ns/1ns
module ssspi_peer (
    input  wire logic clk,
    input  wire logic sck,
    input  wire logic sdo,
    output logic      sdi,
    output logic      sckDrv,
    output logic      ssN
);
    logic [7:0] txByte;
    logic [7:0] rxByte;

    initial begin
        txByte = 8'h00;
        rxByte = 8'h00;
        sckDrv = 1'h0;
        ssN    = 1'h1;
    end

    assign sdi = txByte[7];
    always @(posedge sck) rxByte <= {rxByte[6:0], sdo};
    // Held bit is not kept: the line keeps changing after the frame
    always @(negedge sck) txByte <= {txByte[6:0], ~txByte[0]};

    task automatic load(input logic [7:0] b);
        txByte <= b;
    endtask : load

    task automatic select(input logic v);
        @(posedge clk);
        ssN <= v;
    endtask : select

    // Clock stands still outside frames
    task automatic frame(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            sckDrv <= 1'h1;
            repeat (4) @(posedge clk);
            sckDrv <= 1'h0;
        end
    endtask : frame
endmodule : ssspi_peer

// ### tb/tb.sv
// Self-checking bench for the serial port core and its SPI peer
// Assumes the core answers APB without wait states
`timescale 1ns/1ns
`include "ssspi_defines.svh"
module tb;
    logic                 clk;
    logic                 sys_rst;
    logic [`SSSPI_AW-1:0] paddr;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic                 timerTick;
    logic [31:0]          pwdata;
    logic                 sckLine;
    logic                 sdoLine;
    logic [31:0]          prdata;
    logic [31:0]          rd;
    logic                 errSeen;
    logic pready, pslverr, sckOut, sckOe, sdoOut, sdoOe, sdiW, sckP, ssN;
    logic portIntFlag, portActive, ssPinOwned;
    int                   n_errors = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    int                   nInt = 0;

    always #4 clk = ~clk;

    always @(posedge clk) begin
        timerTick <= (cycles % 4 == 0);
        cycles <= cycles + 1;
        if (portIntFlag === 1'h1) nInt <= nInt + 1;
        if (cycles == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end

    ssspi_core ssspi_core_inst (.clk(clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerTick(timerTick),
        .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
        .sdiIn(sdiW), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .slaveSelectN(ssN), .portIntFlag(portIntFlag),
        .portActive(portActive), .ssPinOwned(ssPinOwned));

    assign sckLine = sckOe ? sckOut : sckP;
    // Data out line has a pull-up when released
    assign sdoLine = sdoOe ? sdoOut : 1'h1;

    ssspi_peer ssspi_peer_inst (.clk(clk), .sck(sckLine),
        .sdo(sdoLine), .sdi(sdiW), .sckDrv(sckP), .ssN(ssN));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd      = prdata;
        errSeen = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // Let the access edge's register updates settle before callers look
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task automatic wait_int();
        int k;
        k = 0;
        while (nInt == 0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk(32'(nInt), 32'h1);
        nInt = 0;
    endtask : wait_int

    task automatic t_reset();
        rdchk(`SSSPI_ADDR_STAT, 32'h0);
        rdchk(`SSSPI_ADDR_CTL, 32'h0);
        chk(portActive, 1'h0);
        rdchk(12'h010, 32'h0);
        chk(errSeen, 1'h1);
        wr(`SSSPI_ADDR_STAT, 32'hff);
        rdchk(`SSSPI_ADDR_STAT, 32'hc0);
        wr(`SSSPI_ADDR_CTL, 32'h5a);
        rdchk(`SSSPI_ADDR_CTL, 32'h5a);
        $display("test reset done");
    endtask : t_reset

    task automatic t_master();
        logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
        wr(`SSSPI_ADDR_STAT, 32'h40);
        foreach (modes[i]) begin
            wr(`SSSPI_ADDR_CTL, {24'h0, 4'h2, modes[i]});
            chk({sckOe, portActive}, 2'h3);
            ssspi_peer_inst.load(8'hc3 ^ 8'(i));
            wr(`SSSPI_ADDR_BUF, 32'h96 ^ i);
            wait_int();
            chk(ssspi_peer_inst.rxByte, 32'h96 ^ i);
            rdchk(`SSSPI_ADDR_STAT, 32'h41);
            rdchk(`SSSPI_ADDR_BUF, 32'hc3 ^ i);
            rdchk(`SSSPI_ADDR_STAT, 32'h40);
        end
        $display("test master done");
    endtask : t_master

    task automatic t_collide();
        wr(`SSSPI_ADDR_CTL, 32'h20);
        ssspi_peer_inst.load(8'h69);
        wr(`SSSPI_ADDR_BUF, 32'ha5);
        wr(`SSSPI_ADDR_BUF, 32'h3c);
        rdchk(`SSSPI_ADDR_CTL, 32'ha0);
        wait_int();
        chk(ssspi_peer_inst.rxByte, 32'ha5);
        rdchk(`SSSPI_ADDR_CTL, 32'ha0);
        rdchk(`SSSPI_ADDR_BUF, 32'h69);
        wr(`SSSPI_ADDR_CTL, 32'h20);
        rdchk(`SSSPI_ADDR_CTL, 32'h20);
        $display("test collision done");
    endtask : t_collide

    task automatic t_slave();
        wr(`SSSPI_ADDR_STAT, 32'h40);
        wr(`SSSPI_ADDR_CTL, 32'h24);
        chk(ssPinOwned, 1'h1);
        wr(`SSSPI_ADDR_BUF, 32'h3c);
        ssspi_peer_inst.load(8'h96);
        ssspi_peer_inst.select(1'h0);
        repeat (2) @(posedge clk);
        chk(sdoOe, 1'h1);
        ssspi_peer_inst.frame(8);
        wait_int();
        chk(ssspi_peer_inst.rxByte, 32'h3c);
        rdchk(`SSSPI_ADDR_BUF, 32'h96);
        ssspi_peer_inst.frame(3);
        ssspi_peer_inst.select(1'h1);
        repeat (2) @(posedge clk);
        chk(sdoOe, 1'h0);
        ssspi_peer_inst.load(8'h5a);
        ssspi_peer_inst.select(1'h0);
        ssspi_peer_inst.frame(8);
        wait_int();
        rdchk(`SSSPI_ADDR_STAT, 32'h41);
        ssspi_peer_inst.load(8'h11);
        ssspi_peer_inst.frame(8);
        wait_int();
        rdchk(`SSSPI_ADDR_CTL, 32'h64);
        rdchk(`SSSPI_ADDR_BUF, 32'h5a);
        ssspi_peer_inst.select(1'h1);
        $display("test slave done");
    endtask : t_slave

    task automatic t_disable();
        wr(`SSSPI_ADDR_CTL, 32'h26);
        chk(ssPinOwned, 1'h0);
        wr(`SSSPI_ADDR_BUF, 32'h77);
        repeat (40) @(posedge clk);
        chk({sckOe, nInt[30:0]}, 32'h0);
        wr(`SSSPI_ADDR_CTL, 32'h00);
        chk({portActive, sdoOe, sckOe}, 3'h0);
        rdchk(`SSSPI_ADDR_STAT, 32'h40);
        $display("test disable done");
    endtask : t_disable

    task automatic t_drain();
        wr(`SSSPI_ADDR_OD, 32'h1);
        wr(`SSSPI_ADDR_CTL, 32'h30);
        chk({sckOe, sckOut}, 2'h0);
        wr(`SSSPI_ADDR_CTL, 32'h20);
        chk({sckOe, sckOut}, 2'h2);
        wr(`SSSPI_ADDR_OD, 32'h0);
        wr(`SSSPI_ADDR_CTL, 32'h25);
        chk({sdoOe, ssPinOwned}, 2'h2);
        $display("test open drain done");
    endtask : t_drain

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        clk       = 1'h0;
        sys_rst   = 1'h1;
        paddr     = '0;
        psel      = 1'h0;
        penable   = 1'h0;
        pwrite    = 1'h0;
        timerTick = 1'h0;
        pwdata    = '0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_master();
        t_collide();
        t_slave();
        t_drain();
        t_disable();
        report_and_stop();
    end
endmodule : tb
